/* inc/rtcctv_defines.svh */
// Offsets, field positions, reset values and timing counts of the RTC control and time block.
`ifndef RTCCTV_DEFINES_SVH
`define RTCCTV_DEFINES_SVH

// ==========================================================================
// Register map
`define RTCCTV_ADDR_W 8
`define RTCCTV_OFF_CTRL 8'h00
`define RTCCTV_OFF_TIME 8'h20

// ==========================================================================
// Control register fields
`define RTCCTV_CTRL_ON 15
`define RTCCTV_CTRL_WREN 3
`define RTCCTV_CTRL_RIPPLE 2
`define RTCCTV_CTRL_HALF 1
`define RTCCTV_CTRL_OE 0

// ==========================================================================
// Time value register fields
`define RTCCTV_HR_T_HI 29
`define RTCCTV_HR_T_LO 28
`define RTCCTV_HR_U_HI 27
`define RTCCTV_HR_U_LO 24
`define RTCCTV_MIN_T_HI 22
`define RTCCTV_MIN_T_LO 20
`define RTCCTV_MIN_U_HI 19
`define RTCCTV_MIN_U_LO 16
`define RTCCTV_SEC_T_HI 14
`define RTCCTV_SEC_T_LO 12
`define RTCCTV_SEC_U_HI 11
`define RTCCTV_SEC_U_LO 8

// ==========================================================================
// Reset values and timing
`define RTCCTV_CTRL_RESET 3'h0
`define RTCCTV_TIME_RESET 20'h00000
`define RTCCTV_CLK_PERIOD_NS 5
`define RTCCTV_HALF_SEC_MS 500
`define RTCCTV_HALF_SEC_CYCLES ((`RTCCTV_HALF_SEC_MS * 1000000) / `RTCCTV_CLK_PERIOD_NS)
`define RTCCTV_RIPPLE_CYCLES 32

`endif

/* inc/rtcctv_pkg.sv */
// Types shared by the RTC control and time block.
package rtcctv_pkg;

   typedef struct packed {
      logic on;
      logic wren;
      logic oe;
   } rtcctv_ctrl_t;

   typedef struct packed {
      logic [1:0] hrTens;
      logic [3:0] hrUnits;
      logic [2:0] minTens;
      logic [3:0] minUnits;
      logic [2:0] secTens;
      logic [3:0] secUnits;
   } rtcctv_time_t;

   typedef struct packed {
      logic write;
      logic [7:0] addr;
   } rtcctv_dph_t;

endpackage : rtcctv_pkg

/* hw/rtcctv_top.sv */
// RTC control register and time-of-day value register behind an AHB-Lite slave.
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "rtcctv_defines.svh"

// Overview of operation
// - Time value writes land only while the value write enable bit is one.
// - The module on bit changes only while value write enable is one.
// - Value write enable sets only while the system unlock input is high.
// - Ripple status is one in the window before a seconds rollover.
// - Half second status is zero in first half, one in second half.
// - Half second status is read only and cleared by a seconds write.
// - Clock output enable bit drives the clock output pin enable.
// - Control register is cleared only by power-on reset.
// - Seconds sit in bits 15:8, tens 14:12, units 11:8, bit 15 zero.
// - All digits are BCD with tens limits two, five, five.
module rtcctv_top
   import rtcctv_pkg::*;
#(
   parameter int unsigned HALF_SEC_CYCLES = `RTCCTV_HALF_SEC_CYCLES,
   parameter int unsigned RIPPLE_CYCLES = `RTCCTV_RIPPLE_CYCLES
) (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic nrst,
   // Other system reset, which leaves the control register alone
   input wire logic sysRstN,
   // System write-unlock state
   input wire logic sysUnlock,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Clock output pin
   output logic rtcClkOut,
   output logic rtcClkOutEn
);

   // ==========================================================================
   // Parameter checks
   localparam int CW = (HALF_SEC_CYCLES > 2) ? $clog2(HALF_SEC_CYCLES) : 2;
   localparam logic [CW-1:0] CNT_END = CW'(HALF_SEC_CYCLES - 1);
   localparam logic [CW-1:0] RIPPLE_START = CW'(HALF_SEC_CYCLES - RIPPLE_CYCLES);

   // Field widths as the register map places them; the packed time type must match them.
   localparam int HR_T_W = `RTCCTV_HR_T_HI - `RTCCTV_HR_T_LO + 1;
   localparam int HR_U_W = `RTCCTV_HR_U_HI - `RTCCTV_HR_U_LO + 1;
   localparam int MIN_T_W = `RTCCTV_MIN_T_HI - `RTCCTV_MIN_T_LO + 1;
   localparam int MIN_U_W = `RTCCTV_MIN_U_HI - `RTCCTV_MIN_U_LO + 1;
   localparam int SEC_T_W = `RTCCTV_SEC_T_HI - `RTCCTV_SEC_T_LO + 1;
   localparam int SEC_U_W = `RTCCTV_SEC_U_HI - `RTCCTV_SEC_U_LO + 1;

   generate
      if (HALF_SEC_CYCLES < 2 || RIPPLE_CYCLES < 1 || RIPPLE_CYCLES >= HALF_SEC_CYCLES) begin : gBadParam
         $error("rtcctv_top: ripple window must be shorter than a half second");
      end
      // A field map that disagrees with the time type would drop or pad digits on reads and writes.
      if (HR_T_W != 2 || HR_U_W != 4 || MIN_T_W != 3 || MIN_U_W != 4) begin : gBadHourMinMap
         $error("rtcctv_top: hour and minute fields do not match the time type");
      end
      if (SEC_T_W != 3 || SEC_U_W != 4 || $bits(rtcctv_time_t) != 20) begin : gBadSecMap
         $error("rtcctv_top: second fields do not match the time type");
      end
      // Both registers must be distinct aligned words inside the decoded address byte.
      if (`RTCCTV_OFF_CTRL == `RTCCTV_OFF_TIME || (`RTCCTV_OFF_CTRL % 4) != 0 ||
          (`RTCCTV_OFF_TIME % 4) != 0) begin : gBadOffsets
         $error("rtcctv_top: register offsets must be distinct aligned words");
      end
      // The status bits must not share a position with the write enable or output enable bit, or with each other.
      if (`RTCCTV_CTRL_RIPPLE == `RTCCTV_CTRL_WREN || `RTCCTV_CTRL_RIPPLE == `RTCCTV_CTRL_OE ||
          `RTCCTV_CTRL_HALF == `RTCCTV_CTRL_WREN || `RTCCTV_CTRL_HALF == `RTCCTV_CTRL_OE ||
          `RTCCTV_CTRL_RIPPLE == `RTCCTV_CTRL_HALF) begin : gBadCtrlMap
         $error("rtcctv_top: control status bits overlap writable bits");
      end
   endgenerate

   // ==========================================================================
   // State
   rtcctv_ctrl_t ctrl;
   rtcctv_ctrl_t next_ctrl;
   rtcctv_time_t tod;
   rtcctv_time_t next_tod;
   rtcctv_time_t todInc;
   rtcctv_time_t todWr;
   rtcctv_dph_t dph;
   rtcctv_dph_t next_dph;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic half_second_status;
   logic next_half_second_status;
   logic next_ripple;

   // ==========================================================================
   // Bus decode
   // Only the low address byte is decoded, and hsize is ignored: every register is one whole word.
   // A write lands in its data phase, one cycle after the address phase that carried it.
   wire addrPhase = hsel & htrans[1] & hready;
   wire hitCtrl = (dph.addr == `RTCCTV_OFF_CTRL);
   wire hitTime = (dph.addr == `RTCCTV_OFF_TIME);
   wire wrCtrl = dph.write & hitCtrl;
   wire wrTime = dph.write & hitTime & ctrl.wren;
   wire secWrite = wrTime;
   wire [7:0] rdAddr = haddr[7:0];

   assign next_dph.write = addrPhase & hwrite;
   assign next_dph.addr = addrPhase ? haddr[7:0] : 8'h00;

   // ==========================================================================
   // Control register next value
   // Clearing value write enable always works; setting it needs the unlock or an already open lock.
   always_comb begin
      next_ctrl = ctrl;
      if (wrCtrl) begin
         next_ctrl.oe = hwdata[`RTCCTV_CTRL_OE];
         next_ctrl.wren = hwdata[`RTCCTV_CTRL_WREN] & (sysUnlock | ctrl.wren);
         if (ctrl.wren) begin
            next_ctrl.on = hwdata[`RTCCTV_CTRL_ON];
         end
      end
   end

   // ==========================================================================
   // Half-second timebase
   // The counter stands still while the module is off, so the time of day holds as well.
   // A time write restarts the second, which keeps the half-second status in step with it.
   wire ticking = ctrl.on;
   wire cntEnd = (cnt == CNT_END);
   wire secTick = ticking & cntEnd & half_second_status;

   always_comb begin
      next_cnt = cnt;
      next_half_second_status = half_second_status;
      if (secWrite) begin
         next_cnt = '0;
         next_half_second_status = 1'b0;
      end else if (ticking) begin
         if (cntEnd) begin
            next_cnt = '0;
            next_half_second_status = ~half_second_status;
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
   end

   // The ripple window covers the last cycles before the time registers roll, so a reader
   // that sees it knows a carry may land between two reads of the time register.
   wire inSecondHalf = next_half_second_status;
   wire inRippleTail = (next_cnt >= RIPPLE_START);
   assign next_ripple = ticking & ~secWrite & inSecondHalf & inRippleTail;

   // ==========================================================================
   // BCD increment of the time of day
   // Hours wrap from twenty-three to zero; every other digit carries at its own limit.
   wire secUCarry = (tod.secUnits == 4'h9);
   wire secTCarry = secUCarry & (tod.secTens == 3'h5);
   wire minUCarry = secTCarry & (tod.minUnits == 4'h9);
   wire minTCarry = minUCarry & (tod.minTens == 3'h5);
   wire dayWrap = minTCarry & (tod.hrTens == 2'h2) & (tod.hrUnits == 4'h3);
   wire hrUCarry = minTCarry & (tod.hrUnits == 4'h9);

   always_comb begin
      todInc = tod;
      todInc.secUnits = secUCarry ? 4'h0 : tod.secUnits + 4'h1;
      if (secUCarry) begin
         todInc.secTens = secTCarry ? 3'h0 : tod.secTens + 3'h1;
      end
      if (secTCarry) begin
         todInc.minUnits = minUCarry ? 4'h0 : tod.minUnits + 4'h1;
      end
      if (minUCarry) begin
         todInc.minTens = minTCarry ? 3'h0 : tod.minTens + 3'h1;
      end
      if (dayWrap) begin
         todInc.hrTens = 2'h0;
         todInc.hrUnits = 4'h0;
      end else if (hrUCarry) begin
         todInc.hrTens = tod.hrTens + 2'h1;
         todInc.hrUnits = 4'h0;
      end else if (minTCarry) begin
         todInc.hrUnits = tod.hrUnits + 4'h1;
      end
   end

   // ==========================================================================
   // Time register next value
   always_comb begin
      todWr.hrTens = hwdata[`RTCCTV_HR_T_HI:`RTCCTV_HR_T_LO];
      todWr.hrUnits = hwdata[`RTCCTV_HR_U_HI:`RTCCTV_HR_U_LO];
      todWr.minTens = hwdata[`RTCCTV_MIN_T_HI:`RTCCTV_MIN_T_LO];
      todWr.minUnits = hwdata[`RTCCTV_MIN_U_HI:`RTCCTV_MIN_U_LO];
      todWr.secTens = hwdata[`RTCCTV_SEC_T_HI:`RTCCTV_SEC_T_LO];
      todWr.secUnits = hwdata[`RTCCTV_SEC_U_HI:`RTCCTV_SEC_U_LO];
   end

   // A software write wins over a rollover in the same cycle.
   assign next_tod = wrTime ? todWr : (secTick ? todInc : tod);

   // ==========================================================================
   // Read data, taken from next values so a read right after a write sees it
   logic [31:0] ctrlWord;
   logic [31:0] timeWord;
   logic [31:0] rdWord;

   always_comb begin
      ctrlWord = 32'h00000000;
      ctrlWord[`RTCCTV_CTRL_ON] = next_ctrl.on;
      ctrlWord[`RTCCTV_CTRL_WREN] = next_ctrl.wren;
      ctrlWord[`RTCCTV_CTRL_RIPPLE] = next_ripple;
      ctrlWord[`RTCCTV_CTRL_HALF] = next_half_second_status;
      ctrlWord[`RTCCTV_CTRL_OE] = next_ctrl.oe;
   end

   always_comb begin
      timeWord = 32'h00000000;
      timeWord[`RTCCTV_HR_T_HI:`RTCCTV_HR_T_LO] = next_tod.hrTens;
      timeWord[`RTCCTV_HR_U_HI:`RTCCTV_HR_U_LO] = next_tod.hrUnits;
      timeWord[`RTCCTV_MIN_T_HI:`RTCCTV_MIN_T_LO] = next_tod.minTens;
      timeWord[`RTCCTV_MIN_U_HI:`RTCCTV_MIN_U_LO] = next_tod.minUnits;
      timeWord[`RTCCTV_SEC_T_HI:`RTCCTV_SEC_T_LO] = next_tod.secTens;
      timeWord[`RTCCTV_SEC_U_HI:`RTCCTV_SEC_U_LO] = next_tod.secUnits;
   end

   always_comb begin
      if (rdAddr == `RTCCTV_OFF_CTRL) begin
         rdWord = ctrlWord;
      end else if (rdAddr == `RTCCTV_OFF_TIME) begin
         rdWord = timeWord;
      end else begin
         rdWord = 32'h00000000;
      end
   end

   wire rdTake = addrPhase & ~hwrite;

   // ==========================================================================
   // Power-on reset domain: control register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= `RTCCTV_CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ==========================================================================
   // Power-on reset domain: timekeeping
   // The timebase and the time of day run on through the other system reset.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tod <= `RTCCTV_TIME_RESET;
         cnt <= '0;
         half_second_status <= 1'b0;
      end else begin
         tod <= next_tod;
         cnt <= next_cnt;
         half_second_status <= next_half_second_status;
      end
   end

   // ==========================================================================
   // Clock output pin
   // The pin carries the half-second status, a square wave with a period of one second.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rtcClkOut <= 1'b0;
         rtcClkOutEn <= 1'b0;
      end else begin
         rtcClkOut <= next_half_second_status;
         rtcClkOutEn <= next_ctrl.oe;
      end
   end

   // ==========================================================================
   // Bus pipeline, also cleared by the other system reset
   // The slave answers with zero wait states and an OKAY response.
   always_ff @(posedge clk) begin
      if (!nrst || !sysRstN) begin
         dph <= '0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         dph <= next_dph;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rdTake) begin
            hrdata <= rdWord;
         end
      end
   end

endmodule : rtcctv_top

/* testbench/rtcctv_asserts.sv */
// Port-level checks of the RTC control and time block.
`timescale 1ns/1ps
`include "rtcctv_defines.svh"
module rtcctv_asserts
   import rtcctv_pkg::*;
(
   // Clock and resets
   input wire logic clk,
   input wire logic nrst,
   input wire logic sysRstN,
   input wire logic sysUnlock,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Clock output pin
   input wire logic rtcClkOut,
   input wire logic rtcClkOutEn
);
   // ==========================================
   // Data phase tracking
   logic wrCtrl;
   logic wrTime;
   logic wren;
   wire logic take = hsel & htrans[1] & hready;
   wire logic [7:0] a = haddr[7:0];
   wire logic rdCtrl = take & !hwrite & (a == `RTCCTV_OFF_CTRL);
   wire logic rdTime = take & !hwrite & (a == `RTCCTV_OFF_TIME);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrCtrl <= 1'b0;
         wrTime <= 1'b0;
         wren <= 1'b0;
      end else begin
         wrCtrl <= take & hwrite & (a == `RTCCTV_OFF_CTRL);
         wrTime <= take & hwrite & (a == `RTCCTV_OFF_TIME);
         if (wrCtrl) wren <= hwdata[3] & (sysUnlock | wren);
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_oe_follows: assert property (wrCtrl |=> rtcClkOutEn == $past(hwdata[0]))
      else $error("output enable mismatch");
   a_half_clear: assert property (wrTime && wren |=> !rtcClkOut)
      else $error("half second not cleared");
   a_half_read: assert property (rdCtrl |=> hrdata[1] == rtcClkOut)
      else $error("half second read mismatch");
   a_ripple_half: assert property (rdCtrl |=> !hrdata[2] || hrdata[1])
      else $error("ripple outside second half");
   a_time_gaps: assert property (rdTime |=> hrdata[31:30] == 2'h0 && !hrdata[23] && !hrdata[15])
      else $error("unused time bit set");
   a_low_byte: assert property (rdTime |=> hrdata[7:0] == 8'h00)
      else $error("time low byte not zero");
   a_bcd_digits: assert property (rdTime |=> hrdata[29:28] <= 2'h2 && hrdata[27:24] <= 4'h9 &&
      hrdata[22:20] <= 3'h5 && hrdata[19:16] <= 4'h9 && hrdata[14:12] <= 3'h5 && hrdata[11:8] <= 4'h9)
      else $error("time digit out of range");
   a_por_clear: assert property (disable iff (1'b0) !nrst |=> !rtcClkOutEn && !rtcClkOut)
      else $error("power-on reset did not clear");
   a_other_keep: assert property (!sysRstN && !wrCtrl |=> $stable(rtcClkOutEn))
      else $error("other reset changed control");
endmodule : rtcctv_asserts

/* testbench/tb_top.sv */
// Directed bench for the RTC control and time block.
`timescale 1ns/1ps
`include "rtcctv_defines.svh"
module tb_top
   import rtcctv_pkg::*;
;
   localparam int HALF = 20;
   localparam logic [7:0] CT = `RTCCTV_OFF_CTRL;
   localparam logic [7:0] TM = `RTCCTV_OFF_TIME;
   logic clk, nrst, sysRstN, sysUnlock, hsel, hwrite, hreadyout, hresp, rtcClkOut, rtcClkOutEn;
   logic [31:0] haddr, hwdata, hrdata, q, p;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic sawHalf = 1'b0;
   logic sawRip = 1'b0;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   rtcctv_top #(.HALF_SEC_CYCLES(HALF), .RIPPLE_CYCLES(4)) u_rtcctv_top (.clk(clk), .nrst(nrst),
      .sysRstN(sysRstN), .sysUnlock(sysUnlock), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rtcClkOut(rtcClkOut), .rtcClkOutEn(rtcClkOutEn));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compared %0d, mismatched %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, ad};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xf
   task automatic rc(input logic [7:0] ad, input logic [31:0] e);
      xf(1'b0, ad, 32'h00000000);
      check(q, e);
   endtask : rc
   initial begin
      {nrst, sysRstN, sysUnlock, hsel, hwrite} = 5'h08;
      {haddr, hwdata, htrans, hsize} = {66'h0, 3'h2};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rc(CT, 32'h00000000);
      rc(TM, 32'h00000000);
      xf(1'b1, 8'h10, 32'hFFFFFFFF);
      rc(8'h10, 32'h00000000);
      check(32'(hresp), 32'h00000000);
      $display("reset test done");
      xf(1'b1, TM, 32'h12345600);
      rc(TM, 32'h00000000);
      xf(1'b1, CT, 32'h00008009);
      rc(CT, 32'h00000001);
      check(32'(rtcClkOutEn), 32'h00000001);
      sysUnlock <= 1'b1;
      xf(1'b1, CT, 32'h00008008);
      rc(CT, 32'h00000008);
      check(32'(rtcClkOutEn), 32'h00000000);
      xf(1'b1, TM, 32'hE3D9D9FF);
      rc(TM, 32'h23595900);
      xf(1'b1, CT, 32'h00008009);
      rc(CT, 32'h00008009);
      repeat (45) @(posedge clk);
      rc(TM, 32'h00000000);
      $display("lock and rollover test done");
      repeat (25) begin
         xf(1'b0, CT, 32'h00000000);
         sawHalf = sawHalf | q[1];
         sawRip = sawRip | q[2];
         if (q[2]) begin
            do begin
               xf(1'b0, TM, 32'h00000000);
               p = q;
               xf(1'b0, TM, 32'h00000000);
            end while (q !== p);
            check(q, 32'h00000100);
         end
      end
      check(32'(sawHalf), 32'h00000001);
      check(32'(sawRip), 32'h00000001);
      repeat (2 * HALF) if (rtcClkOut !== 1'b1) @(posedge clk);
      xf(1'b1, TM, 32'h00000100);
      rc(CT, 32'h00008009);
      repeat (HALF) @(posedge clk);
      rc(CT, 32'h0000800B);
      check(32'(rtcClkOut), 32'h00000001);
      $display("half second test done");
      sysRstN <= 1'b0;
      repeat (3) @(posedge clk);
      sysRstN <= 1'b1;
      @(posedge clk);
      xf(1'b0, CT, 32'h00000000);
      check(q & 32'hFFFFFFF9, 32'h00008009);
      xf(1'b1, CT, 32'h00000000);
      xf(1'b0, CT, 32'h00000000);
      check(q & 32'hFFFFFFF9, 32'h00000000);
      xf(1'b0, TM, 32'h00000000);
      xf(1'b1, TM, 32'h11111100);
      rc(TM, q);
      xf(1'b1, CT, 32'h00000001);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rc(CT, 32'h00000000);
      $display("relock and reset test done");
      summarize();
   end
endmodule : tb_top
bind rtcctv_top rtcctv_asserts u_rtcctv_asserts (.clk(clk), .nrst(nrst), .sysRstN(sysRstN),
   .sysUnlock(sysUnlock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .rtcClkOut(rtcClkOut), .rtcClkOutEn(rtcClkOutEn));
